/* File: shared/urx_defs.svh */
// register map, field positions and reset values of the serial receiver
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH

// register offsets
`define URX_ADDR_IRQ_FLAGS   8'h0c
`define URX_ADDR_RX_STATUS   8'h18
`define URX_ADDR_RX_FIFO     8'h1a
`define URX_ADDR_IRQ_ENABLES 8'h8c
`define URX_ADDR_TX_STATUS   8'h98
`define URX_ADDR_BAUD_DIV    8'h99

// receive_status_control fields
`define URX_RS_SERIAL_PORT_ENABLE  7
`define URX_RS_RX9   6
`define URX_RS_SINGLE_RECEIVE_ENABLE  5
`define URX_RS_CONTINUOUS_RECEIVE_ENABLE  4
`define URX_RS_ADDRESS_DETECT_ENABLE  3
`define URX_RS_FRAMING_ERROR_BIT  2
`define URX_RS_OVERRUN_ERROR_BIT  1
`define URX_RS_RECEIVED_NINTH_BIT  0
`define URX_RS_WMASK 8'hf8

// peripheral flag / enable field
`define URX_IRQ_RX_BIT 5

// transmit_status_control fields
`define URX_TS_SYNC  4
`define URX_TS_HIGH_SPEED_BAUD_SELECT  2
`define URX_TS_TRMT  1
`define URX_TS_WMASK 8'hf5

// reset values
`define URX_RST_RX_STATUS 8'h00
`define URX_RST_TX_STATUS 8'h00
`define URX_RST_IRQ_EN    8'h00
`define URX_RST_BAUD_DIV  8'h00

// oversampling figures
`define URX_OVERSAMPLE    16
`define URX_START_MID     4'h7
`define URX_BIT_MID       4'hf
`define URX_X64_PRESCALE  2'h3

`endif

/* File: shared/urx_pkg.sv */
// types shared by the serial receiver
package urx_pkg;

    // receive bit-level sequencer
    typedef enum logic [1:0] {
        URX_IDLE,
        URX_START,
        URX_DATA,
        URX_STOP
    } urx_state_t;

    // one fifo entry: data with its own status bits
    typedef struct packed {
        logic       framing_error_bit;
        logic       ninth;
        logic [7:0] data;
    } urx_entry_t;

    // register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } urx_bus_req_t;

endpackage

/* File: rtl/urx_top.sv */
// asynchronous serial receiver with two-deep fifo and address detect
`timescale 1ns/1ps
`include "urx_defs.svh"

module urx_top #(
    parameter int FIFO_DEPTH = 2
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    // register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_wr_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // serial line and system state
    input  wire logic       serial_receive_pin_in,
    input  wire logic       sleep_in,
    // interrupt request
    output logic            rx_irq_req_out
);

    localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

    urx_pkg::urx_bus_req_t bus;
    assign bus.addr  = reg_addr_in;
    assign bus.wdata = reg_wdata_in;
    assign bus.wr    = reg_wr_in;
    assign bus.rd    = reg_rd_in;

    // =========================================================
    // software registers
    logic [7:0] rs_ctrl_r;   // writable upper bits of receive status
    logic [7:0] ts_ctrl_r;
    logic [7:0] irq_en_r;
    logic [7:0] baud_div_r;
    logic       overrun_error_bit_r;

    wire wr_rs   = bus.wr && bus.addr == `URX_ADDR_RX_STATUS;
    wire wr_ts   = bus.wr && bus.addr == `URX_ADDR_TX_STATUS;
    wire wr_ien  = bus.wr && bus.addr == `URX_ADDR_IRQ_ENABLES;
    wire wr_baud = bus.wr && bus.addr == `URX_ADDR_BAUD_DIV;
    wire rd_fifo = bus.rd && bus.addr == `URX_ADDR_RX_FIFO;

    // status bits are not stored here, so writes can never reach them
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rs_ctrl_r <= `URX_RST_RX_STATUS;
        end else if (wr_rs) begin
            rs_ctrl_r <= bus.wdata & `URX_RS_WMASK;
        end
    end

    // transmit status is kept only for its mode bits
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ts_ctrl_r <= `URX_RST_TX_STATUS;
        end else if (wr_ts) begin
            ts_ctrl_r <= bus.wdata & `URX_TS_WMASK;
        end
    end

    // only the receive bit acts here, the rest is plain storage
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            irq_en_r <= `URX_RST_IRQ_EN;
        end else if (wr_ien) begin
            irq_en_r <= bus.wdata;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            baud_div_r <= `URX_RST_BAUD_DIV;
        end else if (wr_baud) begin
            baud_div_r <= bus.wdata;
        end
    end

    wire serial_port_enable   = rs_ctrl_r[`URX_RS_SERIAL_PORT_ENABLE];
    wire rx9    = rs_ctrl_r[`URX_RS_RX9];
    wire continuous_receive_enable   = rs_ctrl_r[`URX_RS_CONTINUOUS_RECEIVE_ENABLE];
    wire address_detect_enable   = rs_ctrl_r[`URX_RS_ADDRESS_DETECT_ENABLE];
    wire sync_m = ts_ctrl_r[`URX_TS_SYNC];
    wire high_speed_baud_select   = ts_ctrl_r[`URX_TS_HIGH_SPEED_BAUD_SELECT];

    // receive logic held in reset unless port and continuous receive are enabled, sync is off and not in sleep
    wire rx_run = serial_port_enable && !sync_m && continuous_receive_enable && !sleep_in;

    // =========================================================
    // line synchroniser
    logic rx_m1_r;
    logic rx_m2_r;
    logic rx_m3_r;
    logic rx_s_r;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            rx_m1_r <= 1'b1;
            rx_m2_r <= 1'b1;
            rx_m3_r <= 1'b1;
            rx_s_r  <= 1'b1;
        end else begin
            rx_m1_r <= serial_receive_pin_in;
            rx_m2_r <= rx_m1_r;
            rx_m3_r <= rx_m2_r;
            // glitch of one cycle never reaches the sampler
            if (rx_m2_r == rx_m3_r) begin
                rx_s_r <= rx_m3_r;
            end
        end
    end

    // =========================================================
    // baud generator: tick at x16 (high speed) or x64, then x16 sample
    logic [7:0] brg_cnt_r;
    logic [1:0] presc_r;
    wire        brg_tick = rx_run && brg_cnt_r == baud_div_r;
    wire        smp_tick = brg_tick
                           && (high_speed_baud_select || presc_r == `URX_X64_PRESCALE);

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            brg_cnt_r <= 8'h00;
        end else if (!rx_run || brg_tick) begin
            brg_cnt_r <= 8'h00;
        end else begin
            brg_cnt_r <= brg_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            presc_r <= 2'h0;
        end else if (!rx_run) begin
            presc_r <= 2'h0;
        end else if (brg_tick) begin
            presc_r <= presc_r + 2'h1;
        end
    end

    // =========================================================
    // bit sequencer and receive shift register
    urx_pkg::urx_state_t state_r;
    logic [3:0] os_cnt_r;
    logic [3:0] bit_idx_r;
    logic [8:0] shift_r;
    logic       line_prev_r;
    logic       frame_done;
    logic       stop_low;

    wire [3:0] last_bit = rx9 ? 4'h8 : 4'h7;

    // held high while stopped, so a line already low at enabling is taken as a falling edge
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            line_prev_r <= 1'b1;
        end else if (!rx_run) begin
            line_prev_r <= 1'b1;
        end else if (smp_tick) begin
            line_prev_r <= rx_s_r;
        end
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            state_r   <= urx_pkg::URX_IDLE;
            os_cnt_r  <= 4'h0;
            bit_idx_r <= 4'h0;
        end else if (!rx_run) begin
            state_r   <= urx_pkg::URX_IDLE;
            os_cnt_r  <= 4'h0;
            bit_idx_r <= 4'h0;
        end else if (smp_tick) begin
            os_cnt_r <= os_cnt_r + 4'h1;
            unique case (state_r)
                urx_pkg::URX_IDLE: begin
                    os_cnt_r <= 4'h0;
                    // only a falling edge starts a frame
                    if (line_prev_r && !rx_s_r) begin
                        state_r <= urx_pkg::URX_START;
                    end
                end
                urx_pkg::URX_START: begin
                    if (os_cnt_r == `URX_START_MID) begin
                        os_cnt_r  <= 4'h0;
                        bit_idx_r <= 4'h0;
                        // false start if the line rose again
                        state_r   <= rx_s_r ? urx_pkg::URX_IDLE
                                            : urx_pkg::URX_DATA;
                    end
                end
                urx_pkg::URX_DATA: begin
                    if (os_cnt_r == `URX_BIT_MID) begin
                        bit_idx_r <= bit_idx_r + 4'h1;
                        if (bit_idx_r == last_bit) begin
                            state_r <= urx_pkg::URX_STOP;
                        end
                    end
                end
                urx_pkg::URX_STOP: begin
                    if (os_cnt_r == `URX_BIT_MID) begin
                        state_r <= urx_pkg::URX_IDLE;
                    end
                end
            endcase
        end
    end

    assign frame_done = rx_run && smp_tick && state_r == urx_pkg::URX_STOP
                        && os_cnt_r == `URX_BIT_MID;
    assign stop_low   = !rx_s_r;

    // =========================================================
    // main receive shift register, one bit per bit time
    // recovery stage samples at x16 and hands over only the centre value
    wire bit_strobe = smp_tick && state_r == urx_pkg::URX_DATA
                      && os_cnt_r == `URX_BIT_MID;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            shift_r <= 9'h000;
        end else if (bit_strobe) begin
            shift_r[bit_idx_r] <= rx_s_r;
        end
    end

    // =========================================================
    // acceptance: address filter, overrun
    logic [CNT_W-1:0] count_r;
    wire  fifo_full  = count_r == CNT_W'(FIFO_DEPTH);
    wire  ninth_bit  = rx9 & shift_r[8];
    // filter applies only in nine bit mode
    wire  addr_ok    = !(address_detect_enable && rx9) || shift_r[8];
    // dropped data byte simply stays in the shifter until overwritten
    wire  accept     = frame_done && addr_ok;
    wire  push       = accept && !overrun_error_bit_r && !fifo_full;
    wire  pop        = rd_fifo && count_r != '0;

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            overrun_error_bit_r <= 1'b0;
        end else if (!continuous_receive_enable) begin
            // dropping receive enable is the logic's reset, so it wins
            overrun_error_bit_r <= 1'b0;
        end else if (accept && fifo_full) begin
            overrun_error_bit_r <= 1'b1;
        end
    end

    // =========================================================
    // receive fifo with per-entry status
    urx_pkg::urx_entry_t fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0]    wr_ptr_r;
    logic [PTR_W-1:0]    rd_ptr_r;
    urx_pkg::urx_entry_t new_entry;
    urx_pkg::urx_entry_t head;

    assign new_entry.framing_error_bit  = stop_low;
    assign new_entry.ninth = ninth_bit;
    assign new_entry.data  = shift_r[7:0];

    // a full fifo keeps its entries: the newer word is the one lost
    genvar gi;
    generate
        for (gi = 0; gi < FIFO_DEPTH; gi++) begin : g_entry
            always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
                if (sys_rst_in) begin
                    fifo_mem[gi] <= '0;
                end else if (push && wr_ptr_r == PTR_W'(gi)) begin
                    fifo_mem[gi] <= new_entry;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_W'(FIFO_DEPTH - 1))
                            ? '0 : wr_ptr_r + PTR_W'(1);
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_W'(FIFO_DEPTH - 1))
                            ? '0 : rd_ptr_r + PTR_W'(1);
            end
            // push and pop together leave the count as it is
            if (push && !pop) begin
                count_r <= count_r + CNT_W'(1);
            end else if (pop && !push) begin
                count_r <= count_r - CNT_W'(1);
            end
        end
    end

    // framing and ninth status bits show the head entry, zero when the fifo is empty
    assign head = (count_r != '0) ? fifo_mem[rd_ptr_r] : '0;

    // flag is the fifo's occupancy, so no software clear exists
    wire rx_flag = count_r != '0;

    // =========================================================
    // read path: data one cycle after the strobe
    logic [7:0] rd_val;

    always_comb begin
        rd_val = 8'h00;
        unique case (bus.addr)
            `URX_ADDR_IRQ_FLAGS: rd_val[`URX_IRQ_RX_BIT] = rx_flag;
            `URX_ADDR_RX_STATUS: begin
                rd_val                = rs_ctrl_r;
                rd_val[`URX_RS_FRAMING_ERROR_BIT]  = head.framing_error_bit;
                rd_val[`URX_RS_OVERRUN_ERROR_BIT]  = overrun_error_bit_r;
                rd_val[`URX_RS_RECEIVED_NINTH_BIT]  = head.ninth;
            end
            `URX_ADDR_RX_FIFO:     rd_val = head.data;
            `URX_ADDR_IRQ_ENABLES: rd_val = irq_en_r;
            `URX_ADDR_TX_STATUS: begin
                rd_val               = ts_ctrl_r;
                rd_val[`URX_TS_TRMT] = 1'b1;
            end
            `URX_ADDR_BAUD_DIV:    rd_val = baud_div_r;
            default:               rd_val = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 8'h00;
        end else if (bus.rd) begin
            reg_rdata_out <= rd_val;
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    assign rx_irq_req_out = rx_flag && irq_en_r[`URX_IRQ_RX_BIT];

endmodule

/* File: bench/urx_checker.sv */
// port assertions of the serial receiver
`timescale 1ns/1ps
module urx_checker (
    // clock and reset
    input wire logic       ref_clk_in,
    input wire logic       sys_rst_in,
    // register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_wr_in,
    input wire logic       reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // line, sleep and request
    input wire logic       serial_receive_pin_in,
    input wire logic       sleep_in,
    input wire logic       rx_irq_req_out
);
    logic [7:0] ctl_r;
    logic [7:0] ien_r;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ====
    // shadows of software-written bits
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ctl_r <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == 8'h18) begin
            ctl_r <= reg_wdata_in & 8'hf8;
        end
    end
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            ien_r <= 8'h00;
        end else if (reg_wr_in && reg_addr_in == 8'h8c) begin
            ien_r <= reg_wdata_in;
        end
    end
    // ====
    // assertions
    idle_zero_a:
    assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not zero outside read cycle");
    ctl_read_a:
    assert property (reg_rd_in && reg_addr_in == 8'h18
        |=> reg_rdata_out[7:3] == $past(ctl_r[7:3]))
        else $error("control bits read back wrong");
    overrun_error_bit_clear_a:
    assert property (reg_rd_in && reg_addr_in == 8'h18 && !ctl_r[4]
        |=> !reg_rdata_out[1])
        else $error("overrun seen while receive disabled");
    ien_read_a:
    assert property (reg_rd_in && reg_addr_in == 8'h8c
        |=> reg_rdata_out == $past(ien_r))
        else $error("enable register read back wrong");
    irq_mask_a:
    assert property (rx_irq_req_out |-> ien_r[5])
        else $error("request while masked");
    flag_irq_a:
    assert property (reg_rd_in && reg_addr_in == 8'h0c && ien_r[5]
        |=> reg_rdata_out[5] == $past(rx_irq_req_out))
        else $error("flag and request disagree");
    irq_fall_a:
    assert property ($fell(rx_irq_req_out)
        |-> $past(reg_rd_in && reg_addr_in == 8'h1a)
            || $past(reg_wr_in && reg_addr_in == 8'h8c))
        else $error("request dropped without pop");
    irq_rise_a:
    assert property ($rose(rx_irq_req_out)
        |-> ctl_r[4] || $past(reg_wr_in && reg_addr_in == 8'h8c))
        else $error("request rose while receive disabled");
endmodule

/* File: bench/urx_remote_tx.sv */
// remote asynchronous transmitter driving the receive line
`timescale 1ns/1ps
module urx_remote_tx #(
    parameter int BIT_CLKS = 16
) (
    // clock and reset
    input  wire logic       ref_clk_in,
    input  wire logic       sys_rst_in,
    // frame request
    input  wire logic       go_in,
    input  wire logic [8:0] word_in,
    input  wire logic       nine_in,
    input  wire logic       stop_in,
    // line
    output logic            line_out,
    output logic            busy_out
);
    logic [10:0] sh_r;
    logic [3:0]  bits_r;
    int          tick_r;
    always_ff @(posedge ref_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            sh_r     <= 11'h7ff;
            bits_r   <= 4'h0;
            tick_r   <= 0;
            line_out <= 1'b1;
            busy_out <= 1'b0;
        end else if (!busy_out) begin
            // idle line rests at its pull-up level
            line_out <= 1'b1;
            if (go_in) begin
                // start, data, optional ninth, stop
                sh_r <= nine_in ? {stop_in, word_in, 1'b0}
                                : {1'b1, stop_in, word_in[7:0], 1'b0};
                bits_r   <= nine_in ? 4'hb : 4'ha;
                tick_r   <= 0;
                busy_out <= 1'b1;
            end
        end else begin
            line_out <= sh_r[0];
            if (tick_r == BIT_CLKS - 1) begin
                tick_r <= 0;
                sh_r   <= {1'b1, sh_r[10:1]};
                bits_r <= bits_r - 4'h1;
                if (bits_r == 4'h1) begin
                    busy_out <= 1'b0;
                end
            end else begin
                tick_r <= tick_r + 1;
            end
        end
    end
endmodule

/* File: bench/urx_top_tb.sv */
// self-checking bench of the serial receiver
`timescale 1ns/1ps
module urx_top_tb;
    typedef struct packed {
        logic       nine;
        logic       address_detect_enable;
        logic       stop;
        logic       acc;
        logic [8:0] w;
    } urx_row_t;
    logic       ref_clk_in = 1'b0;
    logic       sys_rst_in = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] rdata;
    logic       line_f;
    logic       line_s;
    logic       glitch_n = 1'b1;
    logic       slow = 1'b0;
    wire        line = line_f & line_s & glitch_n;
    logic       sleep = 1'b0;
    logic       irq;
    logic       go = 1'b0;
    logic [8:0] word = 9'h000;
    logic       nine = 1'b0;
    logic       stop = 1'b1;
    logic       busy_f;
    logic       busy_s;
    wire        busy = busy_f | busy_s;
    int         fail_count = 0;
    int         samples_checked = 0;
    int         cycles = 0;
    urx_row_t   rows [7];
    logic [7:0] ra [7] = '{8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'h00};
    logic [7:0] re [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    urx_top #(.FIFO_DEPTH(2)) u_urx_top (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .serial_receive_pin_in(line), .sleep_in(sleep),
        .rx_irq_req_out(irq));
    urx_remote_tx u_urx_remote_tx (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .go_in(go && !slow), .word_in(word), .nine_in(nine), .stop_in(stop),
        .line_out(line_f), .busy_out(busy_f));
    urx_remote_tx #(.BIT_CLKS(64)) u_urx_remote_tx_x64 (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .go_in(go && slow), .word_in(word), .nine_in(nine), .stop_in(stop),
        .line_out(line_s), .busy_out(busy_s));
    initial begin
        forever #2.5 ref_clk_in = ~ref_clk_in;
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            $display("run cut short at cycle limit");
            tally_and_finish();
        end
    end
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wrr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_in);
        wr <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_in);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_in);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), e, rdata);
    endtask
    task automatic fin();
        for (int i = 0; i < 1000 && busy === 1'b1; i++) begin
            @(posedge ref_clk_in);
            #1;
        end
        repeat (6) @(posedge ref_clk_in);
    endtask
    task automatic send(input logic [8:0] w, input logic n, input logic s);
        fin();
        word <= w;
        nine <= n;
        stop <= s;
        go   <= 1'b1;
        @(posedge ref_clk_in);
        go <= 1'b0;
        @(posedge ref_clk_in);
    endtask
    initial begin
        urx_row_t   c;
        logic [7:0] ctl;
        logic [7:0] st;
        rows = '{'{1'h0, 1'h0, 1'h1, 1'h1, 9'h05a},
                 '{1'h0, 1'h1, 1'h1, 1'h1, 9'h0a5},
                 '{1'h1, 1'h0, 1'h1, 1'h1, 9'h03c},
                 '{1'h1, 1'h0, 1'h1, 1'h1, 9'h1c3},
                 '{1'h1, 1'h1, 1'h1, 1'h1, 9'h181},
                 '{1'h1, 1'h1, 1'h1, 1'h0, 9'h07e},
                 '{1'h0, 1'h0, 1'h0, 1'h1, 9'h0ff}};
        repeat (5) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        for (int i = 0; i < 7; i++) rc(ra[i], re[i]);
        wrr(8'h18, 8'h07);
        rc(8'h18, 8'h00);
        wrr(8'h0c, 8'hff);
        rc(8'h0c, 8'h00);
        $display("test reset and read-only done");
        wrr(8'h98, 8'h04);
        wrr(8'h99, 8'h00);
        wrr(8'h8c, 8'h20);
        wrr(8'h18, 8'h80);
        send(9'h05a, 1'h0, 1'h1);
        fin();
        rc(8'h0c, 8'h00);
        wrr(8'h18, 8'h90);
        sleep <= 1'b1;
        send(9'h05a, 1'h0, 1'h1);
        fin();
        sleep <= 1'b0;
        rc(8'h0c, 8'h00);
        $display("test enable and sleep done");
        for (int i = 0; i < 7; i++) begin
            c = rows[i];
            ctl = {1'h1, c.nine, 2'h1, c.address_detect_enable, 3'h0};
            wrr(8'h18, ctl);
            send(c.w, c.nine, c.stop);
            fin();
            if (c.acc) begin
                rc(8'h0c, 8'h20);
                st = ctl | {5'h00, ~c.stop, 1'h0, c.nine & c.w[8]};
                rc(8'h18, st);
                rc(8'h1a, c.w[7:0]);
            end
            rc(8'h0c, 8'h00);
            $display("test row %0d done", i);
        end
        wrr(8'h18, 8'hd0);
        send(9'h111, 1'h1, 1'h1);
        send(9'h022, 1'h1, 1'h1);
        send(9'h033, 1'h1, 1'h1);
        fin();
        rc(8'h18, 8'hd3);
        rc(8'h1a, 8'h11);
        rc(8'h18, 8'hd2);
        rc(8'h1a, 8'h22);
        rc(8'h0c, 8'h00);
        send(9'h044, 1'h1, 1'h1);
        fin();
        rc(8'h0c, 8'h00);
        wrr(8'h18, 8'hc0);
        rc(8'h18, 8'hc0);
        $display("test overrun done");
        wrr(8'h18, 8'h90);
        wrr(8'h8c, 8'h00);
        send(9'h055, 1'h0, 1'h1);
        fin();
        chk("irq masked", 8'h00, {7'h00, irq});
        rc(8'h0c, 8'h20);
        wrr(8'h8c, 8'h20);
        #1;
        chk("irq enabled", 8'h01, {7'h00, irq});
        rc(8'h1a, 8'h55);
        chk("irq popped", 8'h00, {7'h00, irq});
        $display("test mask done");
        wrr(8'h98, 8'h00);
        slow <= 1'b1;
        send(9'h0c3, 1'h0, 1'h1);
        fin();
        rc(8'h0c, 8'h20);
        rc(8'h1a, 8'hc3);
        slow <= 1'b0;
        wrr(8'h98, 8'h04);
        $display("test slow baud done");
        wrr(8'h18, 8'hd8);
        send(9'h1a5, 1'h1, 1'h1);
        send(9'h066, 1'h1, 1'h1);
        fin();
        rc(8'h1a, 8'ha5);
        rc(8'h0c, 8'h00);
        wrr(8'h18, 8'hd0);
        send(9'h066, 1'h1, 1'h1);
        fin();
        rc(8'h18, 8'hd0);
        rc(8'h1a, 8'h66);
        $display("test address then data done");
        @(posedge ref_clk_in);
        glitch_n <= 1'b0;
        repeat (4) @(posedge ref_clk_in);
        glitch_n <= 1'b1;
        repeat (40) @(posedge ref_clk_in);
        rc(8'h0c, 8'h00);
        $display("test false start done");
        @(posedge ref_clk_in);
        sys_rst_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        rc(8'h18, 8'h00);
        rc(8'h98, 8'h02);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
bind urx_top urx_checker u_urx_checker (
    .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .sleep_in(sleep_in),
    .serial_receive_pin_in(serial_receive_pin_in),
    .rx_irq_req_out(rx_irq_req_out));
